// File: hw/ocdcu_pkg.sv
// package for the on-chip debug command unit: commands, control bits, timing
// assumes a byte-level serial front end outside; no bit timing here
package ocdcu_pkg;
    // ------------------------------------------------------------------
    // command bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_RD_REV = 8'h00;
    localparam logic [7:0] CMD_RSVD = 8'h01;
    localparam logic [7:0] CMD_RD_STAT = 8'h02;
    localparam logic [7:0] CMD_RD_RTC = 8'h03;
    localparam logic [7:0] CMD_WR_CTL = 8'h04;
    localparam logic [7:0] CMD_RD_CTL = 8'h05;
    localparam logic [7:0] CMD_WR_PC = 8'h06;
    localparam logic [7:0] CMD_RD_PC = 8'h07;
    localparam logic [7:0] CMD_RD_MEM = 8'h0B;
    localparam logic [7:0] BRK_OPCODE = 8'h00;
    // ------------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------------
    localparam int CTL_HALT_BIT = 7;
    localparam int CTL_BREAKPOINT_ENABLE_BIT = 6;
    localparam int CTL_ACK_BIT = 5;
    localparam int CTL_RST_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WR_MASK = 8'hE1;
    localparam logic [15:0] RTC_MAX = 16'hFFFF;
    localparam logic [15:0] RTC_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // revision code, value arbitrary
    localparam logic [15:0] DEBUG_REV = 16'h0A5C;
    // ------------------------------------------------------------------
    // APB map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_CTL = 8'h0C;
    localparam logic [7:0] A_RTC = 8'h10;
    localparam logic [7:0] A_OPT = 8'h14;
    // ------------------------------------------------------------------
    // chip reset pulse length
    // ------------------------------------------------------------------
    localparam int CHIP_RST_NS = 40;
    localparam int CLK_NS = 4;
    localparam int CHIP_RST_CYC = (CHIP_RST_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARG0 = 3'b001,
        ST_ARG1 = 3'b010,
        ST_DISC = 3'b011
    } ocdcu_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } ocdcu_byte_t;
endpackage

// File: hw/ocdcu_top.sv
// on-chip debug command unit: decodes host command bytes, owns halt state,
// breakpoint enable, runtime counter and pc access.
// assumes: serial pin already turned into bytes (rxByte) by the link logic,
// cpu reports breakpoint decode and takes pc loads; APB mirrors the unit.
`timescale 1ns/10ps
// How it works
// RQ1: host plants a breakpoint by writing opcode 00H over the instruction
// RQ2: host removes a breakpoint by erasing and reprogramming its page
// RQ3: a sixteen-bit counter counts clock cycles while running
// RQ4: counter runs after leaving halt, stops on halt, saturates at FFFFH
// RQ5: host controls only by command bytes; each byte is decoded here
// RQ6: while running only a small command subset is honoured
// RQ7: revision, status and control reads work in any state
// RQ8: control write works always; under protection cannot clear halt
// RQ9: in halt all commands work unless protection blocks them
// RQ10: protection disables pc write and read commands
// RQ11: protection refuses every program memory read
// RQ12: halt flag stops instruction fetch; clearing it restarts cpu
// RQ13: breakpoint opcode is nop unless enabled; enabled it sets halt
// RQ14: 81H resets then halts chip; 41H resets then runs
// RQ15: reset request resets the chip, not this unit, and self-clears
// RQ16: counter clears to zero whenever halt is left
module ocdcu_top
    import ocdcu_pkg::*;
#(
    parameter int RST_CYCLES = CHIP_RST_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ocdcu_byte_t rxByte,
    output ocdcu_byte_t txByte,
    input wire logic codeReadProtectOption,
    input wire logic brkDecoded,
    input wire logic [15:0] cpuPc,
    output logic debugHaltFlag,
    output logic fetchEnable,
    output logic [15:0] pcLoadValue,
    output logic pcLoad,
    output logic chipResetReq,
    output logic memReadBlocked,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    initial begin
        if (RST_CYCLES < 1 || RST_CYCLES > 255) begin
            $error("RST_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] ctl_q;
    logic [15:0] rtc_q;
    logic [7:0] cmd_q;
    logic [7:0] arg_q;
    logic [7:0] rstCnt_q;
    logic [7:0] lastCmd_q;
    logic refused_q;
    logic optSync0_q, optSync1_q;
    ocdcu_state_t st_q;
    ocdcu_byte_t tx_q;

    // protection option is a strap from outside: two flops first
    always_ff @(posedge sys_clk) begin
        optSync0_q <= codeReadProtectOption;
        optSync1_q <= optSync0_q;
    end
    wire protect = optSync1_q;
    wire halted = ctl_q[CTL_HALT_BIT];

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire cmdStart = rxByte.valid && st_q == ST_IDLE;
    wire [7:0] cmdIn = rxByte.data;
    // RQ7 state-free commands
    wire anyState = cmdIn == CMD_RD_REV || cmdIn == CMD_RD_STAT
        || cmdIn == CMD_RD_CTL || cmdIn == CMD_WR_CTL;
    // RQ10 pc access locked by protection
    wire protBlocked = protect && (cmdIn == CMD_WR_PC || cmdIn == CMD_RD_PC);
    // RQ11 memory reads refused under protection
    wire memBlocked = protect && cmdIn == CMD_RD_MEM;
    // RQ6 RQ9 gate by halt state
    wire allowed = (anyState || halted) && !protBlocked && !memBlocked
        && cmdIn != CMD_RSVD;
    wire needsArg = cmdIn == CMD_WR_CTL || cmdIn == CMD_WR_PC;
    wire argByte = rxByte.valid && (st_q == ST_ARG0 || st_q == ST_ARG1);

    // RQ8 halt cannot be cleared under protection
    wire [7:0] wrCtlRaw = rxByte.data & CTL_WR_MASK;
    wire haltKeep = protect && halted;
    wire [7:0] wrCtl = haltKeep ? (wrCtlRaw | (8'h01 << CTL_HALT_BIT)) : wrCtlRaw;
    wire hostCtlWr = argByte && st_q == ST_ARG0 && cmd_q == CMD_WR_CTL;

    // APB decode
    wire apbAcc = psel && penable;
    wire apbWr = apbAcc && pwrite;
    wire hitCmd = paddr == A_CMD;
    wire hitData = paddr == A_DATA;
    wire hitStat = paddr == A_STAT;
    wire hitCtl = paddr == A_CTL;
    wire hitRtc = paddr == A_RTC;
    wire hitOpt = paddr == A_OPT;
    wire mapped = hitCmd || hitData || hitStat || hitCtl || hitRtc || hitOpt;
    wire apbCtlWr = apbWr && hitCtl;
    wire [7:0] apbCtlRaw = pwdata[7:0] & CTL_WR_MASK;
    wire [7:0] apbCtl = haltKeep ? (apbCtlRaw | (8'h01 << CTL_HALT_BIT)) : apbCtlRaw;

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    // RQ5 byte decode state machine
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cmd_q <= 8'h00;
            arg_q <= 8'h00;
            refused_q <= 1'b0;
            lastCmd_q <= 8'h00;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (cmdStart) begin
                        cmd_q <= cmdIn;
                        lastCmd_q <= cmdIn;
                        refused_q <= !allowed;
                        if (needsArg) begin
                            st_q <= allowed ? ST_ARG0 : ST_DISC;
                        end
                    end
                end
                ST_ARG0: begin
                    if (rxByte.valid) begin
                        arg_q <= rxByte.data;
                        st_q <= cmd_q == CMD_WR_PC ? ST_ARG1 : ST_IDLE;
                    end
                end
                ST_ARG1: begin
                    if (rxByte.valid) begin
                        st_q <= ST_IDLE;
                    end
                end
                // refused writes still swallow their data bytes; a pc write
                // has two, so its first byte only retags the command
                ST_DISC: begin
                    if (rxByte.valid) begin
                        if (cmd_q == CMD_WR_PC) begin
                            cmd_q <= CMD_RSVD;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // reply bytes
    // ------------------------------------------------------------------
    logic [7:0] reply;
    logic replyOk;
    always_comb begin
        reply = 8'h00;
        replyOk = cmdStart && allowed;
        unique case (cmdIn)
            CMD_RD_REV: reply = DEBUG_REV[7:0];
            CMD_RD_STAT: reply = {halted, protect, 6'h00};
            CMD_RD_RTC: reply = rtc_q[7:0];
            CMD_RD_CTL: reply = ctl_q;
            CMD_RD_PC: reply = cpuPc[7:0];
            default: replyOk = 1'b0;
        endcase
    end

    // data is held between replies so the bus can still read the last one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_q <= '0;
        end else begin
            tx_q.valid <= replyOk;
            tx_q.data <= replyOk ? reply : tx_q.data;
        end
    end
    assign txByte = tx_q;

    // ------------------------------------------------------------------
    // control register, reset request
    // ------------------------------------------------------------------
    // RQ15 request clears once the chip reset pulse has run
    wire rstDone = ctl_q[CTL_RST_BIT] && rstCnt_q == 8'(RST_CYCLES - 1);
    // RQ13 enabled breakpoint sets halt
    wire brkHit = brkDecoded && ctl_q[CTL_BREAKPOINT_ENABLE_BIT] && !halted;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_q <= CTL_RESET;
        end else begin
            if (hostCtlWr) begin
                ctl_q <= wrCtl;
            end else if (apbCtlWr) begin
                ctl_q <= apbCtl;
            end else if (rstDone) begin
                ctl_q[CTL_RST_BIT] <= 1'b0;
            end
            // a halt raised by the cpu must not be lost under a same-cycle write
            if (brkHit) begin
                ctl_q[CTL_HALT_BIT] <= 1'b1;
            end
        end
    end

    // RQ14 81H keeps halt through reset, 41H runs after it
    always_ff @(posedge sys_clk) begin
        if (rst || !ctl_q[CTL_RST_BIT]) begin
            rstCnt_q <= 8'h00;
        end else begin
            rstCnt_q <= rstCnt_q + 8'h01;
        end
    end
    // RQ15 only the rest of the chip sees this reset
    assign chipResetReq = ctl_q[CTL_RST_BIT];

    // RQ12 fetch stops while halted
    assign debugHaltFlag = halted;
    assign fetchEnable = !halted && !ctl_q[CTL_RST_BIT];

    // ------------------------------------------------------------------
    // runtime counter
    // ------------------------------------------------------------------
    logic halt_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= halted;
        end
    end
    // clearing one cycle late costs one count: the first running cycle clears the frozen value instead of counting
    wire leaveHalt = halt_q && !halted;
    // RQ3 RQ4 RQ16 count, saturate, clear on resume
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rtc_q <= RTC_RESET;
        end else if (leaveHalt) begin
            rtc_q <= RTC_RESET;
        end else if (!halted && rtc_q != RTC_MAX) begin
            rtc_q <= rtc_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // program counter write
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pcLoadValue <= PC_RESET;
            pcLoad <= 1'b0;
        end else begin
            pcLoad <= argByte && st_q == ST_ARG1;
            if (argByte && st_q == ST_ARG1) begin
                pcLoadValue <= {arg_q, rxByte.data};
            end
        end
    end

    // RQ11 memory path told to refuse reads
    assign memReadBlocked = protect;

    // ------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        if (hitCmd) rdMux = {24'h000000, lastCmd_q};
        if (hitData) rdMux = {24'h000000, tx_q.data};
        if (hitStat) rdMux = {28'h0000000, refused_q, protect, halted, st_q != ST_IDLE};
        if (hitCtl) rdMux = {24'h000000, ctl_q};
        if (hitRtc) rdMux = {16'h0000, rtc_q};
        if (hitOpt) rdMux = {31'h00000000, protect};
    end
    // read data is captured in the setup cycle so prdata comes from a flop;
    // the access cycle only presents it, zero wait states are kept
    logic [31:0] prdata_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= (psel && !penable) ? rdMux : 32'h0000_0000;
        end
    end
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = apbAcc && !mapped;
endmodule

// File: testbench/ocdcu_chk.sv
// checker for the debug command unit: reply timing, gating, reset pulse
// assumes it is bound to ocdcu_top and sees only its ports
`timescale 1ns/10ps
module ocdcu_chk
    import ocdcu_pkg::*;
#(
    parameter int RST_CYCLES = 10
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ocdcu_byte_t rxByte,
    input wire ocdcu_byte_t txByte,
    input wire logic debugHaltFlag,
    input wire logic fetchEnable,
    input wire logic chipResetReq,
    input wire logic memReadBlocked
);
    // ----
    // reset request length
    // ----
    logic [7:0] reqLen_q;
    always_ff @(posedge sys_clk) begin
        if (rst || !chipResetReq) reqLen_q <= 8'h00;
        else reqLen_q <= reqLen_q + 8'h01;
    end
    // argument bytes still owed to a control or pc write, refused ones too
    logic [1:0] argLeft_q;
    always_ff @(posedge sys_clk) begin
        if (rst) argLeft_q <= 2'h0;
        else if (rxByte.valid && argLeft_q != 2'h0) argLeft_q <= argLeft_q - 2'h1;
        else if (rxByte.valid && rxByte.data == CMD_WR_CTL) argLeft_q <= 2'h1;
        else if (rxByte.valid && rxByte.data == CMD_WR_PC) argLeft_q <= 2'h2;
    end
    wire isCmd = rxByte.valid && argLeft_q == 2'h0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    fetch_gate_a: assert property (fetchEnable == (!debugHaltFlag && !chipResetReq))
        else $error("fetch enable disagrees with halt and reset request");
    reset_len_a: assert property (chipResetReq |-> reqLen_q < RST_CYCLES)
        else $error("chip reset request too long");
    halt_keep_a: assert property (memReadBlocked && debugHaltFlag |=> debugHaltFlag)
        else $error("halt cleared while protected");
    rev_reply_a: assert property (isCmd && rxByte.data == CMD_RD_REV
        |=> txByte.valid && txByte.data == DEBUG_REV[7:0])
        else $error("revision reply missing");
    stat_reply_a: assert property (isCmd && rxByte.data == CMD_RD_STAT
        |=> txByte.valid && txByte.data[7:6] == {$past(debugHaltFlag), $past(memReadBlocked)})
        else $error("status reply wrong");
    rtc_gate_a: assert property (!debugHaltFlag && isCmd
        && rxByte.data == CMD_RD_RTC |=> !txByte.valid)
        else $error("counter read answered while running");
    pc_block_a: assert property (memReadBlocked && isCmd
        && rxByte.data == CMD_RD_PC |=> !txByte.valid)
        else $error("pc read answered under protection");
    mem_block_a: assert property (memReadBlocked && isCmd
        && rxByte.data == CMD_RD_MEM |=> !txByte.valid)
        else $error("memory read answered under protection");
endmodule
bind ocdcu_top ocdcu_chk #(.RST_CYCLES(RST_CYCLES)) i_chk (.sys_clk(sys_clk), .rst(rst),
    .rxByte(rxByte), .txByte(txByte), .debugHaltFlag(debugHaltFlag),
    .fetchEnable(fetchEnable), .chipResetReq(chipResetReq), .memReadBlocked(memReadBlocked));

// File: testbench/ocdcu_host.sv
// host debugger model: one command byte in, at most one reply byte back
// assumes byte framing is done; released data shows the inverse value
`timescale 1ns/10ps
module ocdcu_host
    import ocdcu_pkg::*;
(
    input wire logic sys_clk,
    output ocdcu_byte_t rxByte,
    input wire ocdcu_byte_t txByte
);
    initial rxByte = '{data: 8'hFF, valid: 1'h0};
    // bytes only, breakpoints stay in memory
    task automatic cmd(input logic [7:0] b, output logic [31:0] r);
        @(posedge sys_clk);
        rxByte <= '{data: b, valid: 1'h1};
        @(posedge sys_clk);
        rxByte <= '{data: ~b, valid: 1'h0};
        #1;
        r = txByte.valid ? {24'h0, txByte.data} : 32'hFFFFFFFF;
    endtask
endmodule

// File: testbench/ocdcu_bench.sv
// self-checking bench: host bytes, APB and cpu side against a small model
// assumes ocdcu_top with the host model and bound checker; sync reset
`timescale 1ns/10ps
module ocdcu_bench
    import ocdcu_pkg::*;
;
    localparam int RSTC = 4;
    localparam logic [7:0] RUN_CMDS [6] = '{CMD_RD_REV, CMD_RD_STAT, CMD_RD_CTL, CMD_RSVD,
        CMD_RD_RTC, CMD_RD_PC};
    logic sys_clk, rst, codeReadProtectOption, brkDecoded, psel, penable, pwrite, e;
    logic debugHaltFlag, fetchEnable, pcLoad, chipResetReq, memReadBlocked, pready, pslverr;
    logic [7:0] paddr, mCtl;
    logic [15:0] cpuPc, pcLoadValue;
    logic [31:0] pwdata, prdata, q, q2, seed;
    logic mHalt, mProt;
    logic [15:0] mRtc;
    ocdcu_byte_t rxByte, txByte;
    int err_count, n_compared, n;
    ocdcu_host i_host (.sys_clk(sys_clk), .rxByte(rxByte), .txByte(txByte));
    ocdcu_top #(.RST_CYCLES(RSTC)) i_dut (.sys_clk(sys_clk), .rst(rst), .rxByte(rxByte),
        .txByte(txByte), .codeReadProtectOption(codeReadProtectOption),
        .brkDecoded(brkDecoded), .cpuPc(cpuPc), .debugHaltFlag(debugHaltFlag),
        .fetchEnable(fetchEnable), .pcLoadValue(pcLoadValue), .pcLoad(pcLoad),
        .chipResetReq(chipResetReq), .memReadBlocked(memReadBlocked), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ----
    // model and compares
    // ----
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] expReply(input logic [7:0] c);
        if (c == CMD_RD_REV) return {24'h0, DEBUG_REV[7:0]};
        if (c == CMD_RD_STAT) return {24'h0, mHalt, mProt, 6'h00};
        if (c == CMD_RD_CTL) return {24'h0, mCtl};
        if (c == CMD_RD_RTC && mHalt) return {24'h0, mRtc[7:0]};
        if (c == CMD_RD_PC && mHalt && !mProt) return {24'h0, cpuPc[7:0]};
        return 32'hFFFFFFFF;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, s, got, exp);
        end
    endtask
    task automatic chkIn(input logic [31:0] got, input int lo, input int hi, input string s);
        chk($isunknown(got) || got < lo || got > hi, 32'h0, s);
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----
    // bus, host and cpu tasks
    // ----
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'h1) break;
        end
        chk(pready, 1'h1, "apb answer");
        if (pready !== 1'h1) stop_test();
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic ask(input logic [7:0] c);
        i_host.cmd(c, q);
        chk(q, expReply(c), "reply");
    endtask
    task automatic wctl(input logic [7:0] v);
        i_host.cmd(CMD_WR_CTL, q);
        i_host.cmd(v, q);
    endtask
    task automatic rstPulse(input logic [7:0] v);
        wctl(v);
        n = 0;
        repeat (40) @(posedge sys_clk) n += int'(chipResetReq === 1'h1);
        chk(n, RSTC, "reset pulse length");
        chk(debugHaltFlag, v[7], "halt after chip reset");
    endtask
    task automatic breakpoint_opcode(input logic exp);
        @(posedge sys_clk);
        brkDecoded <= 1'h1;
        @(posedge sys_clk);
        brkDecoded <= 1'h0;
        #1;
        chk(debugHaltFlag, exp, "halt on breakpoint");
    endtask
    task automatic wpc(input logic ok);
        q2 = rnd() | 32'h1010;
        i_host.cmd(CMD_WR_PC, q);
        i_host.cmd(q2[15:8], q);
        i_host.cmd(q2[7:0], q);
        chk(pcLoad, ok, "pc load");
        if (ok) chk(pcLoadValue, q2[15:0], "pc value");
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        stop_test();
    end
    initial begin
        seed = 32'h3381;
        err_count = 0;
        n_compared = 0;
        rst = 1'h1;
        codeReadProtectOption = 1'h0;
        {brkDecoded, psel, penable, pwrite, paddr, pwdata, cpuPc} = '0;
        {mHalt, mProt, mCtl, mRtc} = '0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        apb(1'h0, A_CTL, 32'h0);
        chk(q, 32'h0, "ctl reset value");
        apb(1'h0, 8'h20, 32'h0);
        chk(e, 1'h1, "unmapped address");
        $display("test reset and map done");
        for (int i = 0; i < 6; i++) begin
            ask(RUN_CMDS[i]);
        end
        breakpoint_opcode(1'h0);
        $display("test running commands done");
        rstPulse(8'h41);
        breakpoint_opcode(1'h1);
        rstPulse(8'h81);
        {mHalt, mCtl} = {1'h1, 8'h80};
        @(posedge sys_clk);
        q2 = rnd();
        cpuPc <= q2[15:0];
        ask(CMD_RD_CTL);
        ask(CMD_RD_PC);
        wpc(1'h1);
        $display("test halt commands done");
        apb(1'h1, A_CTL, 32'h0);
        repeat (100) @(posedge sys_clk);
        apb(1'h1, A_CTL, 32'h80);
        apb(1'h0, A_RTC, 32'h0);
        chkIn(q, 100, 103, "counter one run");
        apb(1'h0, A_RTC, 32'h0);
        chkIn(q, 100, 103, "counter frozen");
        apb(1'h1, A_CTL, 32'h0);
        repeat (65600) @(posedge sys_clk);
        apb(1'h1, A_CTL, 32'h80);
        apb(1'h0, A_RTC, 32'h0);
        chk(q, {16'h0, RTC_MAX}, "counter saturates");
        mRtc = RTC_MAX;
        ask(CMD_RD_RTC);
        ask(CMD_RD_STAT);
        $display("test counter done");
        codeReadProtectOption <= 1'h1;
        repeat (4) @(posedge sys_clk);
        {mProt, mCtl} = {1'h1, 8'hA0};
        ask(CMD_RD_PC);
        ask(CMD_RD_MEM);
        wpc(1'h0);
        wctl(8'h20);
        ask(CMD_RD_CTL);
        ask(CMD_RD_STAT);
        chk(memReadBlocked, 1'h1, "memory reads locked");
        $display("test protection done");
        @(posedge sys_clk);
        rst <= 1'h1;
        codeReadProtectOption <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        {mHalt, mProt, mCtl} = '0;
        ask(CMD_RD_CTL);
        chk(fetchEnable, 1'h1, "fetch after reset");
        $display("test second reset done");
        stop_test();
    end
endmodule
